/* src/adc_host_pkg.sv */
// Constants and rule summary for the converter host controller
// What this block does
// - Write strobe with select low starts a conversion in write-then-read mode.
// - Later read strobe with select low returns the finished result.
// - Polling host waits for completion low before the result read; the block reads anyway once its poll count reaches TIMEOUT_CYC.
// - Evenly spaced starts come from a precise timer, not software.
// - Interrupt-driven starts are spaced to allow reading the previous result.
// - Falling completion can pulse select and read, pushing results into a FIFO.
// - Mode input low selects read-only mode, high selects write-then-read.
// - Host may skip completion and lower read 250 ns after write rises.
package adc_host_pkg;
	localparam int CLK_MHZ       = 25;
	localparam int PULSE_NS      = 100;
	localparam int INTL_NS       = 380;
	localparam int FASTRD_NS     = 250;
	localparam int RDDATA_NS     = 120;
	localparam int PULSE_CYC     = (PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int INTL_CYC      = (INTL_NS * CLK_MHZ + 999) / 1000;
	localparam int FASTRD_CYC    = (FASTRD_NS * CLK_MHZ + 999) / 1000;
	localparam int RDDATA_CYC    = (RDDATA_NS * CLK_MHZ + 999) / 1000;
	localparam int TIMEOUT_CYC   = 4 * INTL_CYC;
	localparam int DATA_W        = 8;
	localparam int FIFO_DEPTH    = 4;
	localparam logic [7:0] BIPOLAR_FLIP = 8'h80;
endpackage : adc_host_pkg

/* src/sample_fifo.sv */
// Small flip-flop FIFO between the converter port and the consumer
module sample_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("sample_fifo depth must be a power of two, at least 2");
	end
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [WIDTH-1:0] nxt_mem [DEPTH];
	logic [AW-1:0]    wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
	logic [AW:0]      count_ff, nxt_count;
	logic             doWr, doRd;

	assign inReady  = (count_ff != (AW+1)'(DEPTH));
	assign outValid = (count_ff != '0);
	assign outData  = mem_ff[rdPtr_ff];
	assign doWr     = inValid && inReady;
	assign doRd     = outValid && outReady;

	always_comb begin
		nxt_mem   = mem_ff;
		nxt_wrPtr = wrPtr_ff;
		nxt_rdPtr = rdPtr_ff;
		nxt_count = count_ff;
		if (doWr) begin
			nxt_mem[wrPtr_ff] = inData;
			nxt_wrPtr = wrPtr_ff + 1'b1;
		end
		if (doRd)
			nxt_rdPtr = rdPtr_ff + 1'b1;
		if (doWr && !doRd)
			nxt_count = count_ff + 1'b1;
		else if (doRd && !doWr)
			nxt_count = count_ff - 1'b1;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wrPtr_ff <= '0;
			rdPtr_ff <= '0;
			count_ff <= '0;
		end else begin
			wrPtr_ff <= nxt_wrPtr;
			rdPtr_ff <= nxt_rdPtr;
			count_ff <= nxt_count;
		end
		mem_ff <= nxt_mem;
	end

	a_fifo_no_overflow: assert property (@(posedge sys_clk) disable iff (rst)
		count_ff <= (AW+1)'(DEPTH))
		else $error("FIFO count above depth");
endmodule : sample_fifo

/* src/adc_host_ctrl.sv */
// Host controller that starts conversions and buffers results from the converter
module adc_host_ctrl
	import adc_host_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             sampleTick,
	input  wire logic             fastRead,
	input  wire logic             bipolar,
	output logic                  selectN,
	output logic                  writeN,
	output logic                  readN,
	output logic                  modeSel,
	input  wire logic             doneN,
	input  wire logic [WIDTH-1:0] resultBus,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  signedOut,
	output logic                  overrun,
	output logic                  busy
);
	if (WIDTH != DATA_W) begin : g_bad_width
		$error("adc_host_ctrl serves only an 8-bit converter");
	end

	// Strobes are decoded from the state, so they change only just after an edge
	typedef enum {IDLE, WRITE, WAITDONE, READ, CAPTURE, PUSH} state_e;
	state_e          state_ff, nxt_state;
	// One counter serves strobe width, poll time and read access in turn
	logic [7:0]      cnt_ff, nxt_cnt;
	logic [WIDTH-1:0] data_ff, nxt_data;
	logic            overrun_ff, nxt_overrun;
	logic            fifoReady;

	assign modeSel = 1'b1;
	assign busy    = (state_ff != IDLE);
	assign overrun = overrun_ff;
	assign signedOut = bipolar;

	always_comb begin
		nxt_state   = state_ff;
		nxt_cnt     = cnt_ff;
		nxt_data    = data_ff;
		nxt_overrun = overrun_ff;
		selectN     = 1'b1;
		writeN      = 1'b1;
		readN       = 1'b1;
		case (state_ff)
			IDLE: begin
				if (sampleTick) begin
					nxt_state = WRITE;
					nxt_cnt   = 8'(PULSE_CYC);
				end
			end
			WRITE: begin
				// Width rounded up to whole cycles, so the strobe is never short
				selectN = 1'b0;
				writeN  = 1'b0;
				if (cnt_ff == 8'h01) begin
					nxt_state = WAITDONE;
					nxt_cnt   = 8'h00;
				end else begin
					nxt_cnt = cnt_ff - 8'h01;
				end
			end
			WAITDONE: begin
				nxt_cnt = cnt_ff + 8'h01;
				if (fastRead && cnt_ff + 8'h01 >= 8'(FASTRD_CYC)) begin
					nxt_state = READ;
					nxt_cnt   = 8'(RDDATA_CYC);
				end else if (!fastRead && !doneN) begin
					nxt_state = READ;
					nxt_cnt   = 8'(RDDATA_CYC);
				end else if (cnt_ff >= 8'(TIMEOUT_CYC)) begin
					// A silent device is read anyway, so the host never hangs
					nxt_state = READ;
					nxt_cnt   = 8'(RDDATA_CYC);
				end
			end
			READ: begin
				// Access time rounded up to whole cycles
				selectN = 1'b0;
				readN   = 1'b0;
				if (cnt_ff == 8'h01)
					nxt_state = CAPTURE;
				else
					nxt_cnt = cnt_ff - 8'h01;
			end
			CAPTURE: begin
				// Last low read cycle, well after the data has settled
				selectN   = 1'b0;
				readN     = 1'b0;
				nxt_data  = resultBus;
				nxt_state = PUSH;
			end
			PUSH: begin
				// Strobes stay idle while the FIFO is full; lost ticks show as overrun
				if (fifoReady)
					nxt_state = IDLE;
			end
			default: nxt_state = IDLE;
		endcase
		// starts too close set the single overrun flag, which only reset clears
		if (sampleTick && state_ff != IDLE)
			nxt_overrun = 1'b1;
	end

	// Registers only; every next value is formed above
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_ff   <= IDLE;
			cnt_ff     <= 8'h00;
			data_ff    <= '0;
			overrun_ff <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			data_ff    <= nxt_data;
			overrun_ff <= nxt_overrun;
		end
	end

	// Buffer so a slow consumer can take results in batches
	sample_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) fifo (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.inValid  (state_ff == PUSH),
		.inReady  (fifoReady),
		.inData   (data_ff),
		.outValid (outValid),
		.outReady (outReady),
		.outData  (outData)
	);

	// Strobe and sequencing checks; counts follow the package timing
	// write lasts the pulse
	a_write_pulse_len: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(writeN) |-> (!writeN && !selectN) [*3] ##1 writeN)
		else $error("write strobe length wrong");
	a_write_with_sel: assert property (@(posedge sys_clk) disable iff (rst)
		!writeN |-> !selectN)
		else $error("write without select");
	a_no_strobe_overlap: assert property (@(posedge sys_clk) disable iff (rst)
		writeN || readN)
		else $error("write and read low together");
	a_read_after_write: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(writeN) |-> readN [*2])
		else $error("read too soon after write");
	a_poll_read_edge: assert property (@(posedge sys_clk) disable iff (rst)
		(state_ff == WAITDONE && !fastRead && !doneN) |=> !readN)
		else $error("completion seen but no read");
	a_poll_wait: assert property (@(posedge sys_clk) disable iff (rst)
		(state_ff == WAITDONE && !fastRead && doneN && cnt_ff < 8'(TIMEOUT_CYC))
		|=> readN)
		else $error("read before completion");
	a_timeout_read: assert property (@(posedge sys_clk) disable iff (rst)
		(state_ff == WAITDONE && cnt_ff >= 8'(TIMEOUT_CYC)) |=> !readN)
		else $error("no read after poll timeout");
	a_fast_read_gap: assert property (@(posedge sys_clk) disable iff (rst)
		($rose(writeN) && fastRead) |-> readN [*7])
		else $error("fast read before 250 ns");
	a_fast_read_edge: assert property (@(posedge sys_clk) disable iff (rst)
		($rose(writeN) && fastRead) |-> ##7 !readN)
		else $error("fast read late");
	a_read_pulse_len: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(readN) |-> (!readN && !selectN) [*4] ##1 readN)
		else $error("read strobe length wrong");
	a_read_bus_sel: assert property (@(posedge sys_clk) disable iff (rst)
		!readN |-> !selectN && writeN)
		else $error("read without select");
	a_idle_strobes: assert property (@(posedge sys_clk) disable iff (rst)
		!busy |-> selectN && writeN && readN)
		else $error("strobe active while idle");
	a_capture_push: assert property (@(posedge sys_clk) disable iff (rst)
		(state_ff == CAPTURE) |=> (state_ff == PUSH) && data_ff == $past(resultBus))
		else $error("result not captured");
	a_push_stall: assert property (@(posedge sys_clk) disable iff (rst)
		(state_ff == PUSH && !fifoReady) |=> (state_ff == PUSH) && selectN)
		else $error("push left while FIFO full");
	a_tick_start: assert property (@(posedge sys_clk) disable iff (rst)
		(state_ff == IDLE && sampleTick) |=> !writeN)
		else $error("tick did not start");
	a_write_from_idle: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(writeN) |-> !$past(busy))
		else $error("write started while busy");
	a_overrun_flag: assert property (@(posedge sys_clk) disable iff (rst)
		(sampleTick && busy) |=> overrun)
		else $error("overrun not flagged");
	a_overrun_sticky: assert property (@(posedge sys_clk) disable iff (rst)
		overrun |=> overrun)
		else $error("overrun cleared");
	a_mode_high: assert property (@(posedge sys_clk) disable iff (rst)
		modeSel)
		else $error("mode not write-then-read");
endmodule : adc_host_ctrl

/* testbench/adc_device_model.sv */
// Behavioural converter answering the host controller's strobes
module adc_device_model (
	input  wire logic        selectN,
	input  wire logic        writeN,
	input  wire logic        readN,
	input  wire logic        modeSel,
	input  wire logic [7:0]  analogCode,
	input  wire logic [15:0] convNs,
	output logic             doneN,
	output logic      [7:0]  resultBus
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] held  = 8'h00;
	logic       armed = 1'b0;
	initial doneN = 1'b1;
	// input taken 50 ns after the write falls
	// Select is looked at then: it falls in the same time step, in no fixed order
	always @(negedge writeN) begin
		#50;
		if (!selectN && modeSel) begin
			held  = analogCode;
			armed = 1'b1;
		end
	end
	// completion after the conversion time; select rises with the write
	always @(posedge writeN) begin : convTimer
		if (armed) begin
			armed = 1'b0;
			#(convNs) doneN = 1'b0;
		end
	end
	// early read pulls completion low and cuts the timer
	always @(negedge readN) begin
		#1;
		if (!selectN) begin
			disable convTimer;
			doneN = 1'b0;
		end
	end
	// rising read or select releases completion
	always @(posedge readN or posedge selectN) doneN = 1'b1;
	// code driven only while read; released bus shows garbage
	assign resultBus = (!selectN && !readN) ? held : ~held;
endmodule : adc_device_model

/* testbench/adc_write_read_conversion_port_bench.sv */
// Self-checking bench for the converter host controller
module adc_write_read_conversion_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk = 0, rst = 1, sampleTick = 0, fastRead = 0, bipolar = 0, outReady = 0;
	logic        selectN, writeN, readN, modeSel, doneN, outValid, signedOut, overrun, busy;
	logic [7:0]  resultBus, outData, analogCode = 8'h00;
	logic [15:0] convNs = 16'd380;
	int          errors = 0, n_compared = 0;
	always #20 sys_clk = ~sys_clk;
	adc_host_ctrl DUT (.sys_clk(sys_clk), .rst(rst), .sampleTick(sampleTick),
		.fastRead(fastRead), .bipolar(bipolar), .selectN(selectN), .writeN(writeN),
		.readN(readN), .modeSel(modeSel), .doneN(doneN), .resultBus(resultBus),
		.outValid(outValid), .outReady(outReady), .outData(outData),
		.signedOut(signedOut), .overrun(overrun), .busy(busy));
	adc_device_model DEV (.selectN(selectN), .writeN(writeN), .readN(readN),
		.modeSel(modeSel), .analogCode(analogCode), .convNs(convNs), .doneN(doneN),
		.resultBus(resultBus));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic convert(input logic [7:0] code, output int k);
		analogCode = code;
		sampleTick = 1'b1;
		@(posedge sys_clk) #1;
		sampleTick = 1'b0;
		for (k = 0; k < 80 && busy === 1'b1; k++) @(posedge sys_clk) #1;
		chk("busy", 8'h00, {7'h0, busy});
	endtask : convert
	task automatic pop(input logic [7:0] exp);
		for (int k = 0; k < 4 && outValid !== 1'b1; k++) @(posedge sys_clk) #1;
		chk("outValid", 8'h01, {7'h0, outValid});
		chk("outData", exp, outData);
		outReady = 1'b1;
		@(posedge sys_clk) #1;
		outReady = 1'b0;
	endtask : pop
	task automatic t_polled;
		int c;
		convert(8'ha5, c);
		pop(8'ha5);
		chk("polledCycles", 8'h01, {7'h0, c > 16 && c < 30});
		chk("signedOut", 8'h00, {7'h0, signedOut});
		chk("overrun", 8'h00, {7'h0, overrun});
	endtask : t_polled
	task automatic t_bipolar;
		int c;
		bipolar = 1'b1;
		convert(8'h80, c);
		pop(8'h80);
		chk("signedOut", 8'h01, {7'h0, signedOut});
		chk("modeSel", 8'h01, {7'h0, modeSel});
		bipolar = 1'b0;
	endtask : t_bipolar
	task automatic t_fast;
		int c;
		// Device slower than the poll timeout, so only the early read can keep it short
		convNs = 16'd2000;
		fastRead = 1'b1;
		convert(8'h3c, c);
		pop(8'h3c);
		chk("fastCycles", 8'h01, {7'h0, c > 13 && c < 20});
		fastRead = 1'b0;
		// Same slow device polled: the poll timeout must end the wait and read anyway
		convert(8'hc3, c);
		pop(8'hc3);
		chk("timeoutCycles", 8'h01, {7'h0, c > 44 && c < 60});
		convNs = 16'd380;
	endtask : t_fast
	task automatic t_fifo;
		int c;
		for (int i = 1; i <= 4; i++) convert(i[7:0], c);
		analogCode = 8'h55;
		sampleTick = 1'b1;
		repeat (2) @(posedge sys_clk) #1;
		sampleTick = 1'b0;
		chk("overrun", 8'h01, {7'h0, overrun});
		// Long enough for the fifth word to reach the full FIFO and stall there
		repeat (30) @(posedge sys_clk) #1;
		chk("stalled", 8'h01, {7'h0, busy});
		chk("strobesStalled", 8'h07, {5'h0, selectN, writeN, readN});
		for (int i = 1; i <= 4; i++) pop(i[7:0]);
		for (int k = 0; k < 80 && busy === 1'b1; k++) @(posedge sys_clk) #1;
		pop(8'h55);
	endtask : t_fifo
	task automatic results;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	initial begin
		#200us;
		errors++;
		results();
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		#1 rst = 1'b0;
		chk("strobes", 8'h07, {5'h0, selectN, writeN, readN});
		t_polled();
		t_bipolar();
		t_fast();
		t_fifo();
		results();
	end
endmodule : adc_write_read_conversion_port_bench
